// [hw/ipc_pkg.sv]
// Constants and types for the isolated pulse link coder.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
package ipc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int LEVEL_FAST_PS = 62500;
  localparam int LEVEL_SLOW_PS = 500000;
  localparam int BIT_FAST_PS = 375000;
  localparam int BIT_SLOW_PS = 3000000;
  localparam int MIN_PULSE_NS = 50;
  localparam int SLICES_PER_BIT = 3;
  localparam int CNT_W = 9;
  // Nearest whole cycle; fast slice of 12.5 cycles at 100 MHz rounds to 13
  localparam logic [7:0] SLICE_FAST_CYC =
    8'((2 * LEVEL_FAST_PS * CLK_MHZ + 500000) / 1000000);
  localparam logic [7:0] SLICE_SLOW_CYC =
    8'((2 * LEVEL_SLOW_PS * CLK_MHZ + 500000) / 1000000);
  localparam logic [2:0] MIN_PULSE_CYC =
    3'((MIN_PULSE_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TX_DATA = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_MIN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam int CTRL_NORMAL_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_LEN_LSB = 8;
  localparam int LEN_W = 5;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_BIT = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] WAKE_MIN_RST = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pos;
    logic neg;
  } ipc_line_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PULSE = 2'b01,
    TX_PAUSE = 2'b11
  } ipc_tx_state_t;

  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_BLANK = 1'b1
  } ipc_rx_state_t;
endpackage : ipc_pkg

// [hw/ipc_link_coder.sv]
// Isolated pulse link coder: pulse symbol transmitter, receiver,
// stand-by wake counter and AXI4-Lite register slave.
// Pin inputs are synchronous to aclk; the line inputs are the
// digital outputs of the differential comparators.
`timescale 1ns/1ps
`default_nettype none
module ipc_link_coder #(
  parameter int DATA_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_rate_select,
  input wire logic tx_impedance_select,
  input wire ipc_pkg::ipc_line_t iso_line_in,
  output ipc_pkg::ipc_line_t iso_line_out,
  output ipc_pkg::ipc_line_t iso_line_oe,
  output logic tx_imp_high_o,
  output logic rx_enable_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ipc_pkg::ipc_tx_state_t tx_state_reg, tx_state_next;
  logic [ipc_pkg::CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
  logic tx_pause2_reg, tx_pause2_next;
  logic [ipc_pkg::LEN_W-1:0] tx_left_reg, tx_left_next;
  logic [DATA_W-1:0] tx_shift_reg, tx_shift_next;
  logic [7:0] tx_slice_reg, tx_slice_next;
  ipc_pkg::ipc_line_t out_reg, out_next, oe_reg, oe_next;
  logic tx_done_ev;
  ipc_pkg::ipc_rx_state_t rx_state_reg, rx_state_next;
  logic [ipc_pkg::CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] pos_run_reg, pos_run_next, neg_run_reg, neg_run_next;
  logic [DATA_W-1:0] rx_shift_reg, rx_shift_next;
  logic [5:0] rx_count_reg, rx_count_next;
  logic [7:0] wake_cnt_reg, wake_cnt_next;
  logic wake_flag_reg, wake_flag_next;
  logic rx_bit_ev, wake_ev, in_pos, in_neg, pos_hit, neg_hit;
  logic [7:0] rate_slice;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic normal_reg, normal_next, start_reg, start_next;
  logic [ipc_pkg::LEN_W-1:0] len_reg, len_next;
  logic [DATA_W-1:0] tx_data_reg, tx_data_next;
  logic [7:0] wake_min_reg, wake_min_next;
  logic [ipc_pkg::IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic irq_reg, irq_next, imp_reg, rx_en_reg, rx_en_next;
  logic do_wr, do_rd, rd_clear;
  logic [31:0] wr_val;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Fast or slow slice length from the strap
  assign rate_slice = line_rate_select ? ipc_pkg::SLICE_FAST_CYC
                                       : ipc_pkg::SLICE_SLOW_CYC;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg + 9'h001;
    tx_pause2_next = tx_pause2_reg;
    tx_left_next = tx_left_reg;
    tx_shift_next = tx_shift_reg;
    tx_slice_next = tx_slice_reg;
    tx_done_ev = 1'b0;
    unique case (tx_state_reg)
      ipc_pkg::TX_IDLE: begin
        tx_cnt_next = '0;
        if (start_reg && normal_reg) begin
          tx_state_next = ipc_pkg::TX_PULSE;
          tx_shift_next = tx_data_reg;
          tx_left_next = len_reg;
          tx_slice_next = rate_slice;
        end
      end
      ipc_pkg::TX_PULSE: begin
        if (tx_cnt_reg == {1'b0, tx_slice_reg} - 9'h001) begin
          tx_cnt_next = '0;
          tx_pause2_next = 1'b0;
          tx_state_next = ipc_pkg::TX_PAUSE;
        end
      end
      ipc_pkg::TX_PAUSE: begin
        if (tx_cnt_reg == {1'b0, tx_slice_reg} - 9'h001) begin
          tx_cnt_next = '0;
          tx_pause2_next = 1'b1;
          if (tx_pause2_reg) begin
            if (tx_left_reg == '0) begin
              tx_state_next = ipc_pkg::TX_IDLE;
              tx_done_ev = 1'b1;
            end else begin
              tx_state_next = ipc_pkg::TX_PULSE;
              tx_left_next = tx_left_reg - 5'h01;
              tx_shift_next = tx_shift_reg >> 1;
              tx_slice_next = rate_slice;
            end
          end
        end
      end
      default: begin
        tx_state_next = ipc_pkg::TX_IDLE;
      end
    endcase
    // First level follows the bit, second the inverse
    if (tx_state_next == ipc_pkg::TX_PULSE) begin
      if (tx_cnt_next < {2'b00, tx_slice_next[7:1]}) begin
        out_next.pos = tx_shift_next[0];
      end else begin
        out_next.pos = ~tx_shift_next[0];
      end
      out_next.neg = ~out_next.pos;
    end else begin
      out_next = '0;
    end
    oe_next.pos = tx_state_next != ipc_pkg::TX_IDLE;
    oe_next.neg = oe_next.pos;
  end

  // ----------------------------------------------------------------
  // Receiver and wake counter
  // ----------------------------------------------------------------
  assign in_pos = iso_line_in.pos & ~iso_line_in.neg;
  assign in_neg = iso_line_in.neg & ~iso_line_in.pos;
  // Qualify once a level has stood long enough
  assign pos_hit = in_pos && pos_run_reg == ipc_pkg::MIN_PULSE_CYC - 3'h1;
  assign neg_hit = in_neg && neg_run_reg == ipc_pkg::MIN_PULSE_CYC - 3'h1;

  always_comb begin
    pos_run_next = in_pos ? pos_run_reg : '0;
    neg_run_next = in_neg ? neg_run_reg : '0;
    if (in_pos && pos_run_reg != ipc_pkg::MIN_PULSE_CYC) begin
      pos_run_next = pos_run_reg + 3'h1;
    end
    if (in_neg && neg_run_reg != ipc_pkg::MIN_PULSE_CYC) begin
      neg_run_next = neg_run_reg + 3'h1;
    end
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg + 9'h001;
    rx_shift_next = rx_shift_reg;
    rx_count_next = rd_clear ? 6'h00 : rx_count_reg;
    rx_bit_ev = 1'b0;
    rx_en_next = normal_reg && tx_state_next == ipc_pkg::TX_IDLE;
    unique case (rx_state_reg)
      ipc_pkg::RX_HUNT: begin
        rx_cnt_next = '0;
        if (rx_en_reg && (pos_hit || neg_hit)) begin
          rx_shift_next = {pos_hit, rx_shift_reg[DATA_W-1:1]};
          rx_bit_ev = 1'b1;
          rx_state_next = ipc_pkg::RX_BLANK;
          if (rx_count_next != 6'(DATA_W)) begin
            rx_count_next = rx_count_next + 6'h01;
          end
        end
      end
      ipc_pkg::RX_BLANK: begin
        // Skip the rest of the pulse and the first pause
        if (rx_cnt_reg >= {rate_slice, 1'b0} - 9'h001) begin
          rx_state_next = ipc_pkg::RX_HUNT;
        end
      end
    endcase
    wake_cnt_next = wake_cnt_reg;
    wake_flag_next = wake_flag_reg;
    wake_ev = 1'b0;
    if (normal_reg) begin
      wake_cnt_next = '0;
      wake_flag_next = 1'b0;
    end else begin
      if ((pos_hit || neg_hit) && wake_cnt_reg != 8'hFF) begin
        wake_cnt_next = wake_cnt_reg + 8'h01;
      end
      if (!wake_flag_reg && wake_cnt_next > wake_min_reg) begin
        wake_flag_next = 1'b1;
        wake_ev = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------
  assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign rd_clear = do_rd && s_axi_araddr == ipc_pkg::ADDR_RX_DATA;

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    normal_next = normal_reg;
    start_next = 1'b0;
    len_next = len_reg;
    tx_data_next = tx_data_reg;
    wake_min_next = wake_min_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    wr_val = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = ipc_pkg::RESP_OKAY;
      unique case (aw_addr_reg)
        ipc_pkg::ADDR_CTRL: begin
          wr_val = merge({19'h0, len_reg, 7'h0, normal_reg},
                         w_data_reg, w_strb_reg);
          normal_next = wr_val[ipc_pkg::CTRL_NORMAL_BIT];
          start_next = wr_val[ipc_pkg::CTRL_START_BIT];
          len_next = wr_val[ipc_pkg::CTRL_LEN_LSB +: ipc_pkg::LEN_W];
        end
        ipc_pkg::ADDR_TX_DATA: begin
          tx_data_next = merge(tx_data_reg, w_data_reg, w_strb_reg);
        end
        ipc_pkg::ADDR_WAKE_MIN: begin
          wr_val = merge({24'h0, wake_min_reg}, w_data_reg, w_strb_reg);
          wake_min_next = wr_val[7:0];
        end
        ipc_pkg::ADDR_IRQ_STAT: begin
          if (w_strb_reg[0]) begin
            stat_next = stat_reg & ~w_data_reg[ipc_pkg::IRQ_W-1:0];
          end
        end
        ipc_pkg::ADDR_IRQ_MASK: begin
          wr_val = merge({29'h0, mask_reg}, w_data_reg, w_strb_reg);
          mask_next = wr_val[ipc_pkg::IRQ_W-1:0];
        end
        ipc_pkg::ADDR_STATUS, ipc_pkg::ADDR_RX_DATA: begin
        end
        default: bresp_next = ipc_pkg::RESP_DECERR;
      endcase
    end
    // Hardware set wins over the write-one clear
    stat_next = stat_next | {wake_ev, rx_bit_ev, tx_done_ev};
    if (do_rd) begin
      rvalid_next = 1'b1;
      rresp_next = ipc_pkg::RESP_OKAY;
      rdata_next = '0;
      unique case (s_axi_araddr)
        ipc_pkg::ADDR_CTRL:
          rdata_next = {19'h0, len_reg, 7'h0, normal_reg};
        ipc_pkg::ADDR_STATUS:
          rdata_next = {18'h0, rx_count_reg, 4'h0, wake_flag_reg,
                        tx_impedance_select, line_rate_select,
                        tx_state_reg != ipc_pkg::TX_IDLE};
        ipc_pkg::ADDR_TX_DATA: rdata_next = tx_data_reg;
        ipc_pkg::ADDR_RX_DATA: rdata_next = rx_shift_reg;
        ipc_pkg::ADDR_WAKE_MIN: rdata_next = {24'h0, wake_min_reg};
        ipc_pkg::ADDR_IRQ_STAT: rdata_next = {29'h0, stat_reg};
        ipc_pkg::ADDR_IRQ_MASK: rdata_next = {29'h0, mask_reg};
        default: rresp_next = ipc_pkg::RESP_DECERR;
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg <= ipc_pkg::TX_IDLE;
      tx_cnt_reg <= '0;
      tx_pause2_reg <= 1'b0;
      tx_left_reg <= '0;
      tx_shift_reg <= '0;
      tx_slice_reg <= ipc_pkg::SLICE_SLOW_CYC;
      out_reg <= '0;
      oe_reg <= '0;
      rx_state_reg <= ipc_pkg::RX_HUNT;
      rx_cnt_reg <= '0;
      pos_run_reg <= '0;
      neg_run_reg <= '0;
      rx_shift_reg <= '0;
      rx_count_reg <= '0;
      wake_cnt_reg <= '0;
      wake_flag_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ipc_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= ipc_pkg::RESP_OKAY;
      rdata_reg <= '0;
      normal_reg <= 1'b0;
      start_reg <= 1'b0;
      len_reg <= '0;
      tx_data_reg <= '0;
      wake_min_reg <= ipc_pkg::WAKE_MIN_RST;
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
      imp_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_pause2_reg <= tx_pause2_next;
      tx_left_reg <= tx_left_next;
      tx_shift_reg <= tx_shift_next;
      tx_slice_reg <= tx_slice_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      pos_run_reg <= pos_run_next;
      neg_run_reg <= neg_run_next;
      rx_shift_reg <= rx_shift_next;
      rx_count_reg <= rx_count_next;
      wake_cnt_reg <= wake_cnt_next;
      wake_flag_reg <= wake_flag_next;
      rx_en_reg <= rx_en_next;
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      normal_reg <= normal_next;
      start_reg <= start_next;
      len_reg <= len_next;
      tx_data_reg <= tx_data_next;
      wake_min_reg <= wake_min_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      imp_reg <= tx_impedance_select;
    end
  end

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign iso_line_out = out_reg;
  assign iso_line_oe = oe_reg;
  assign tx_imp_high_o = imp_reg;
  assign rx_enable_o = rx_en_reg;
  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [ipc_pkg::CNT_W-1:0] sym_len_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || (tx_state_next == ipc_pkg::TX_PULSE &&
                     tx_state_reg != ipc_pkg::TX_PULSE)) begin
      sym_len_reg <= '0;
    end else begin
      sym_len_reg <= sym_len_reg + 9'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_drive_excl_rx: assert property (oe_reg.pos |-> !rx_en_reg)
    else $error("transmitter drives while receiver enabled");
  a_no_both_high: assert property (!(out_reg.pos && out_reg.neg))
    else $error("both line halves driven high");
  a_open_polarity: assert property (
    tx_state_reg == ipc_pkg::TX_PULSE && $past(tx_state_reg) !=
    ipc_pkg::TX_PULSE |-> out_reg.pos == tx_shift_reg[0])
    else $error("pulse opens with wrong polarity");
  a_bit_span: assert property (
    tx_state_reg == ipc_pkg::TX_PULSE &&
    $past(tx_state_reg) == ipc_pkg::TX_PAUSE |->
    $past(sym_len_reg) == 3 * $past(tx_slice_reg) - 1)
    else $error("bit symbol length wrong");
  a_rate_pick: assert property (
    tx_state_reg == ipc_pkg::TX_PULSE &&
    $past(tx_state_reg) == ipc_pkg::TX_IDLE |->
    tx_slice_reg == ($past(line_rate_select) ? ipc_pkg::SLICE_FAST_CYC
                                             : ipc_pkg::SLICE_SLOW_CYC))
    else $error("slice length ignores rate strap");
  a_slice_split: assert property (
    $rose(out_reg.pos) && tx_state_reg == ipc_pkg::TX_PULSE &&
    tx_cnt_reg != 9'h000 |-> tx_cnt_reg == {2'b00, tx_slice_reg[7:1]})
    else $error("second pulse level starts off mid slice");
  a_wake_above: assert property (
    $rose(wake_flag_reg) |-> wake_cnt_reg > wake_min_reg &&
    !$past(normal_reg))
    else $error("wake raised without enough pulses");
  a_short_pulse: assert property (
    pos_hit |-> $past(in_pos, 4) && $past(in_pos, 2) && $past(in_pos))
    else $error("pulse counted before it stood long enough");
  a_imp_follow: assert property (
    tx_impedance_select ##1 tx_impedance_select |-> tx_imp_high_o)
    else $error("impedance output ignores strap");
  a_rx_bit_val: assert property (
    rx_en_reg && rx_state_reg == ipc_pkg::RX_HUNT && neg_hit && !pos_hit
    |=> !rx_shift_reg[DATA_W-1])
    else $error("received bit does not follow polarity");
endmodule : ipc_link_coder
`default_nettype wire

// [sim/ipc_far_end.sv]
// Far-end transceiver model: drives the comparator levels seen by the
// coder. Waits until the coder releases the line before starting each pulse.
`timescale 1ns/1ps
`default_nettype none
module ipc_far_end (
  input wire logic aclk,
  input wire ipc_pkg::ipc_line_t dut_oe,
  output ipc_pkg::ipc_line_t line_o
);
  // ------------------------------------------------------------
  // Pulse generator
  // ------------------------------------------------------------
  initial line_o = '0;

  // One pulse of given polarity, then a quiet gap
  task automatic pulse(input logic pol, input int len, input int gap);
    @(posedge aclk);
    wait (dut_oe == '0);
    line_o <= '{pos: pol, neg: !pol};
    repeat (len) @(posedge aclk);
    line_o <= '0;
    repeat (gap) @(posedge aclk);
  endtask : pulse
endmodule : ipc_far_end
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the isolated pulse link coder.
// Assumes a far-end model driving the comparator inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, imp_o, rx_en, irq;
  logic [1:0] bresp, rresp;
  logic rate = 1'b0, imp = 1'b0;
  ipc_pkg::ipc_line_t l_in, l_out, l_oe;
  logic [33:0] exp_q[$];
  int n_errors = 0, num_checks = 0, s;
  logic [31:0] d;

  always #5 aclk = ~aclk;

  ipc_link_coder DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_rate_select(rate),
    .tx_impedance_select(imp), .iso_line_in(l_in), .iso_line_out(l_out),
    .iso_line_oe(l_oe), .tx_imp_high_o(imp_o), .rx_enable_o(rx_en),
    .irq_o(irq));

  ipc_far_end u_far (.aclk(aclk), .dut_oe(l_oe), .line_o(l_in));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    if (bvalid && bready) chk("bresp", {32'h0, bresp}, exp_q.pop_front());
    if (rvalid && rready) chk("read", {rresp, rdata}, exp_q.pop_front());
  end

  // ------------------------------------------------------------
  // AXI4-Lite master
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    exp_q.push_back({32'h0, ipc_pkg::RESP_OKAY});
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    repeat (2) @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, v});
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
  endtask : rd

  // Two-bit transmission at the given rate, checked at the pins
  task automatic tx_run(input logic fast);
    int k;
    d = $urandom;
    s = fast ? int'(ipc_pkg::SLICE_FAST_CYC) : int'(ipc_pkg::SLICE_SLOW_CYC);
    rate <= fast;
    wr(ipc_pkg::ADDR_TX_DATA, d);
    fork
      wr(ipc_pkg::ADDR_CTRL, 32'h0000_0103);
    join_none
    // Align to the middle of the first pulse cycle
    @(posedge l_oe.pos);
    @(negedge aclk);
    for (k = 0; k < 2; k++) begin
      chk("pulse head", l_out.pos, d[k]);
      chk("rx off", rx_en, 1'b0);
      repeat (s - 1) @(negedge aclk);
      chk("pulse tail", l_out.neg, d[k]);
      @(negedge aclk);
      chk("pause", {l_out, l_oe}, 4'b0011);
      repeat (2 * s) @(negedge aclk);
    end
    chk("release", {rx_en, l_oe}, 3'b100);
    @(posedge aclk);
  endtask : tx_run

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h6BFF961B));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(ipc_pkg::ADDR_CTRL, 32'h0, ipc_pkg::RESP_OKAY);
    rd(ipc_pkg::ADDR_WAKE_MIN, 32'h8, ipc_pkg::RESP_OKAY);
    rd(8'h1C, 32'h0, ipc_pkg::RESP_DECERR);
    imp <= 1'($urandom);
    repeat (3) @(posedge aclk);
    chk("imp", imp_o, imp);
    rd(ipc_pkg::ADDR_STATUS, {29'h0, imp, 2'b00}, ipc_pkg::RESP_OKAY);
    tx_run(1'b1);
    tx_run(1'b0);
    rate <= 1;
    s = int'(ipc_pkg::SLICE_FAST_CYC);
    u_far.pulse(1, s, 2 * s);
    u_far.pulse(0, s, 2 * s);
    u_far.pulse(1, s, 2 * s);
    rd(ipc_pkg::ADDR_STATUS, {18'h0, 6'h3, 5'h0, imp, 2'b10},
       ipc_pkg::RESP_OKAY);
    rd(ipc_pkg::ADDR_RX_DATA, 32'hA000_0000, ipc_pkg::RESP_OKAY);
    wr(ipc_pkg::ADDR_CTRL, 32'h0);
    wr(ipc_pkg::ADDR_WAKE_MIN, 32'h3);
    wr(ipc_pkg::ADDR_IRQ_STAT, 32'h7);
    wr(ipc_pkg::ADDR_IRQ_MASK, 32'h4);
    u_far.pulse(1, 4, 20);
    repeat (3) u_far.pulse(1, 8, 20);
    rd(ipc_pkg::ADDR_STATUS, {29'h0, imp, 2'b10}, ipc_pkg::RESP_OKAY);
    u_far.pulse(0, 8, 20);
    rd(ipc_pkg::ADDR_STATUS, {28'h0, 1'b1, imp, 2'b10},
       ipc_pkg::RESP_OKAY);
    chk("irq raised", irq, 1'b1);
    wr(ipc_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(ipc_pkg::ADDR_IRQ_MASK, 32'h4);
    chk("irq unmasked", irq, 1'b1);
    wr(ipc_pkg::ADDR_IRQ_STAT, 32'h4);
    chk("irq cleared", irq, 1'b0);
    rd(ipc_pkg::ADDR_IRQ_STAT, 32'h0, ipc_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end
endmodule : tb
`default_nettype wire
